// file: logic/rsi_reset_init.sv
// reset sequencer and state initialiser with an ahb-lite register view
`default_nettype none
`include "rsi_defs.svh"
module rsi_reset_init
  import rsi_pkg::*;
#(
  parameter int unsigned STAB_CYCLES = `RSI_STAB_CYCLES
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // reset pin, active low, asynchronous to hclk
  input  wire logic        ext_reset_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // program memory vector port
  output logic [15:0]      pmem_addr,
  output logic             pmem_rd,
  input  wire logic [7:0]  pmem_data,
  // cpu side
  output logic             cpu_run,
  output logic [13:0]      start_pc,
  output logic             mem_bank_enable,
  output logic             reg_bank_enable,
  output logic             serial0_clock_latch,
  output logic [15:0]      port_latch_out
);

  localparam logic [21:0] WAIT_LAST = 22'(STAB_CYCLES - 1);

  rsi_regs_t  r;
  rsi_regs_t  n;
  logic       mem_we;
  logic [7:0] mem_waddr;
  logic [3:0] mem_wdata;
  logic [3:0] mem_rdata;

  ////////////////////////////////////////////////////////////////////////////////////
  // register read view

  function automatic logic [31:0] reg_read(input rsi_regs_t s, input logic [11:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (a[11:6] == 6'h00) begin
      case (a[5:0])
        `RSI_OFF_CTRL:   d = {20'h0, s.clock_output_control, s.system_clock_select,
                              s.cpu_clock_control};
        `RSI_OFF_STATUS: d = {16'h0, s.state, 6'h0, s.standby, s.cpu_run};
        `RSI_OFF_CPU:    d = {4'h0, s.reg_bank_select, s.mem_bank_select, s.reg_bank_enable,
                              s.mem_bank_enable, s.int_status_bits, s.skip_flags,
                              s.carry_flag, s.pc};
        `RSI_OFF_STACK:  d = {4'h0, s.approx_result_reg, s.basic_interval_count,
                              s.stack_bank_select, s.stack_pointer};
        `RSI_OFF_GREG:   d = s.greg;
        `RSI_OFF_TIMER:  d = {2'h0, s.event_out_level, s.event_output_enable,
                              s.basic_interval_control, s.event_counter_control,
                              s.event_counter_modulo, s.event_counter_value};
        `RSI_OFF_PULSE:  d = {s.watch_control, s.pulse_gen_control, s.pulse_period_low,
                              s.pulse_period_high};
        `RSI_OFF_SER0:   d = {s.slave_addr_reg, s.serial_bus_control, s.serial0_control,
                              s.serial0_shift_reg};
        `RSI_OFF_SER1:   d = {6'h0, s.serial0_clock_latch, s.serial1_done_flag,
                              s.converter_control, s.serial1_control, s.serial1_shift_reg};
        `RSI_OFF_INT:    d = {3'h0, s.int_master_enable, s.ext_int_edge_select,
                              s.interrupt_enable_flags, s.int_request_flags};
        `RSI_OFF_PORT:   d = {s.port_pullup_group_a, s.port_dir_groups, s.port_latch};
        `RSI_OFF_SEQBUF: d = {16'h0, s.bit_seq_buffers};
        default:         d = 32'h0000_0000;
      endcase
    end
    return d;
  endfunction : reg_read

  ////////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    n         = r;
    mem_we    = 1'b0;
    mem_waddr = 8'h00;
    mem_wdata = 4'h0;
    // reset pin synchroniser
    n.rst_meta = ext_reset_n;
    n.rst_sync = r.rst_meta;
    n.pmem_rd  = 1'b0;
    n.hready   = 1'b1;
    n.hresp    = 1'b0;
    n.a_write  = 1'b0;
    n.a_ram_rd = 1'b0;
    if (r.a_ram_rd) begin
      n.hrdata = {28'h0, mem_rdata};
    end
    // address phase
    if (hsel && htrans[1] && hready) begin
      n.a_addr  = haddr[11:0];
      n.a_write = hwrite;
      if (!hwrite) begin
        if (haddr[11:10] == `RSI_RAM_SEL) begin
          // one wait state: memory read data arrive a cycle late
          n.a_ram_rd = 1'b1;
          n.hready   = 1'b0;
        end else begin
          n.hrdata = reg_read(r, haddr[11:0]);
        end
      end
    end
    // data phase write, only while the cpu runs so reset always wins
    if (r.a_write && r.cpu_run && r.rst_sync) begin
      if (r.a_addr[11:10] == `RSI_RAM_SEL) begin
        mem_we    = 1'b1;
        mem_waddr = r.a_addr[9:2];
        mem_wdata = hwdata[3:0];
      end else if (r.a_addr[11:6] == 6'h00) begin
        case (r.a_addr[5:0])
          `RSI_OFF_CTRL:  {n.clock_output_control, n.system_clock_select,
                           n.cpu_clock_control} = hwdata[11:0];
          `RSI_OFF_CPU:   {n.reg_bank_select, n.mem_bank_select, n.reg_bank_enable,
                           n.mem_bank_enable, n.int_status_bits, n.skip_flags,
                           n.carry_flag, n.pc} = hwdata[27:0];
          `RSI_OFF_STACK: {n.approx_result_reg, n.basic_interval_count,
                           n.stack_bank_select, n.stack_pointer} = hwdata[27:0];
          `RSI_OFF_GREG:  n.greg = hwdata;
          `RSI_OFF_TIMER: {n.event_out_level, n.event_output_enable,
                           n.basic_interval_control, n.event_counter_control,
                           n.event_counter_modulo, n.event_counter_value} = hwdata[29:0];
          `RSI_OFF_PULSE: {n.watch_control, n.pulse_gen_control, n.pulse_period_low,
                           n.pulse_period_high} = hwdata;
          `RSI_OFF_SER0:  {n.slave_addr_reg, n.serial_bus_control, n.serial0_control,
                           n.serial0_shift_reg} = hwdata;
          `RSI_OFF_SER1:  {n.serial0_clock_latch, n.serial1_done_flag, n.converter_control,
                           n.serial1_control, n.serial1_shift_reg} = hwdata[25:0];
          `RSI_OFF_INT:   {n.int_master_enable, n.ext_int_edge_select,
                           n.interrupt_enable_flags, n.int_request_flags} = hwdata[28:0];
          `RSI_OFF_PORT:  {n.port_pullup_group_a, n.port_dir_groups,
                           n.port_latch} = hwdata;
          `RSI_OFF_SEQBUF: n.bit_seq_buffers = hwdata[15:0];
          default: begin
          end
        endcase
      end
    end
    // sequencer
    case (r.state)
      RSI_ST_HOLD: begin
        if (r.rst_sync) begin
          n.state      = RSI_ST_SCRUB;
          n.scrub_addr = r.standby ? `RSI_SCRUB_LO : 8'h00;
        end
      end
      RSI_ST_SCRUB: begin
        // a standby reset only loses the f8h-fdh window
        mem_we    = 1'b1;
        mem_waddr = r.scrub_addr;
        mem_wdata = `RSI_UNDEF_NIB;
        if (r.scrub_addr == (r.standby ? `RSI_SCRUB_HI : `RSI_SCRUB_END)) begin
          n.state    = RSI_ST_WAIT;
          n.wait_cnt = 22'h0;
        end else begin
          n.scrub_addr = r.scrub_addr + 8'h01;
        end
      end
      RSI_ST_WAIT: begin
        if (r.wait_cnt == WAIT_LAST) begin
          n.state = RSI_ST_VEC_A;
        end else begin
          n.wait_cnt = r.wait_cnt + 22'h1;
        end
      end
      RSI_ST_VEC_A: begin
        n.pmem_rd   = 1'b1;
        n.pmem_addr = `RSI_VEC_ADDR_HI;
        n.state     = RSI_ST_VEC_B;
      end
      RSI_ST_VEC_B: begin
        n.pmem_rd   = 1'b1;
        n.pmem_addr = `RSI_VEC_ADDR_LO;
        n.state     = RSI_ST_VEC_C;
      end
      RSI_ST_VEC_C: begin
        n.vec_hi = pmem_data;
        n.state  = RSI_ST_VEC_D;
      end
      RSI_ST_VEC_D: begin
        n.pc              = {r.vec_hi[5:0], pmem_data};
        n.reg_bank_enable = r.vec_hi[6];
        n.mem_bank_enable = r.vec_hi[7];
        n.cpu_run         = 1'b1;
        n.state           = RSI_ST_RUN;
      end
      RSI_ST_RUN: begin
      end
      default: n.state = RSI_ST_HOLD;
    endcase
    // reset pin low: stop or halt gives no resume, the sequence restarts
    if (!r.rst_sync) begin
      n.state   = RSI_ST_HOLD;
      n.cpu_run = 1'b0;
      n.pmem_rd = 1'b0;
      // standby is taken from the cpu clock control before it is cleared
      if (r.state != RSI_ST_HOLD) begin
        n.standby = r.cpu_clock_control[`RSI_CLKCTL_STOP_BIT] |
                    r.cpu_clock_control[`RSI_CLKCTL_HALT_BIT];
      end
      n.skip_flags      = 3'h0;
      n.int_status_bits = 2'h0;
      n.mem_bank_select = 4'h0;
      n.reg_bank_select = 2'h0;
      // stack pointer, stack bank, interval count and result register keep
      // whatever they hold: they are undefined after either reset
      n.basic_interval_control = 4'h0;
      n.watch_control          = 8'h00;
      n.event_counter_value    = 8'h00;
      n.event_counter_modulo   = `RSI_MODULO_RST;
      n.event_counter_control  = 8'h00;
      n.event_output_enable    = 1'b0;
      n.event_out_level        = 1'b0;
      n.pulse_gen_control      = 8'h00;
      n.serial0_control        = 8'h00;
      n.serial_bus_control     = 8'h00;
      n.serial0_clock_latch    = `RSI_SER0_CLK_RST;
      n.converter_control      = `RSI_CONV_RST;
      n.cpu_clock_control      = 4'h0;
      n.system_clock_select    = 4'h0;
      n.clock_output_control   = 4'h0;
      n.serial1_control        = 8'h00;
      n.serial1_done_flag      = 1'b0;
      n.int_request_flags      = 8'h00;
      n.interrupt_enable_flags = 8'h00;
      n.int_master_enable      = 1'b0;
      n.ext_int_edge_select    = 12'h000;
      n.port_latch             = 16'h0000;
      n.port_dir_groups        = 12'h000;
      n.port_pullup_group_a    = 4'h0;
      // an operating reset poisons what a standby reset keeps
      if (!n.standby) begin
        n.carry_flag        = 1'b1;
        n.greg              = {4{`RSI_UNDEF_BYTE}};
        n.serial0_shift_reg = `RSI_UNDEF_BYTE;
        n.slave_addr_reg    = `RSI_UNDEF_BYTE;
        n.serial1_shift_reg = `RSI_UNDEF_BYTE;
        n.bit_seq_buffers   = {2{`RSI_UNDEF_BYTE}};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= RSI_REGS_RST;
    end else begin
      r <= n;
    end
  end

  rsi_data_mem u_mem (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .we       (mem_we),
    .waddr    (mem_waddr),
    .wdata    (mem_wdata),
    .raddr    (haddr[9:2]),
    .rdata_ff (mem_rdata)
  );

  assign hreadyout           = r.hready;
  assign hrdata              = r.hrdata;
  assign hresp               = r.hresp;
  assign pmem_addr           = r.pmem_addr;
  assign pmem_rd             = r.pmem_rd;
  assign cpu_run             = r.cpu_run;
  assign start_pc            = r.pc;
  assign mem_bank_enable     = r.mem_bank_enable;
  assign reg_bank_enable     = r.reg_bank_enable;
  assign serial0_clock_latch = r.serial0_clock_latch;
  assign port_latch_out      = r.port_latch;

  ////////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence vec_reads_s;
    (r.pmem_rd && r.pmem_addr == `RSI_VEC_ADDR_HI) ##1
    (r.pmem_rd && r.pmem_addr == `RSI_VEC_ADDR_LO) ##1 !r.pmem_rd;
  endsequence

  sequence vec_load_s;
    (r.state == RSI_ST_VEC_D) ##1 (r.cpu_run && r.pc[13:8] == r.vec_hi[5:0]);
  endsequence

  hold_on_pin_a: assert property (!r.rst_sync |=> (r.state == RSI_ST_HOLD && !r.cpu_run))
    else $error("reset pin low did not hold the sequencer");
  wait_len_a: assert property ((r.state == RSI_ST_WAIT && r.rst_sync) |=>
    (r.state == (($past(r.wait_cnt) == WAIT_LAST) ? RSI_ST_VEC_A : RSI_ST_WAIT)))
    else $error("stabilisation wait length wrong");
  vec_fetch_a: assert property ((r.state == RSI_ST_VEC_A && r.rst_sync) |=> vec_reads_s)
    else $error("vector bytes not fetched in order");
  pc_load_a: assert property ((r.state == RSI_ST_VEC_D && r.rst_sync) |->
    vec_load_s ##0 (r.pc[7:0] == $past(pmem_data)))
    else $error("program counter not loaded from vector");
  bank_en_a: assert property ($rose(r.cpu_run) |-> ($past(r.state) == RSI_ST_VEC_D &&
    r.mem_bank_enable == r.vec_hi[7] && r.reg_bank_enable == r.vec_hi[6]))
    else $error("bank enables wrong at start of run");
  psw_clear_a: assert property (!r.rst_sync |=> (r.skip_flags == 3'h0 &&
    r.int_status_bits == 2'h0 && r.mem_bank_select == 4'h0 && r.reg_bank_select == 2'h0))
    else $error("status or bank select not cleared");
  timer_init_a: assert property (!r.rst_sync |=> (r.event_counter_value == 8'h00 &&
    r.event_counter_modulo == `RSI_MODULO_RST && !r.event_output_enable && !r.event_out_level))
    else $error("event counter not initialised");
  periph_init_a: assert property (!r.rst_sync |=> (r.converter_control == `RSI_CONV_RST &&
    r.serial0_clock_latch && r.int_request_flags == 8'h00 && !r.int_master_enable))
    else $error("peripheral reset values wrong");
  pulse_keep_a: assert property (!r.rst_sync |=> ($stable(r.pulse_period_high) &&
    $stable(r.pulse_period_low) && $stable(r.stack_pointer)))
    else $error("held register changed by reset");
  standby_keep_a: assert property ((!r.rst_sync && r.state == RSI_ST_HOLD && r.standby) |=>
    ($stable(r.greg) && $stable(r.bit_seq_buffers)))
    else $error("standby reset lost retained state");
  standby_rec_a: assert property ((!r.rst_sync && r.state == RSI_ST_RUN &&
    r.cpu_clock_control[3:2] != 2'h0) |=> r.standby)
    else $error("standby not recorded at reset");
  scrub_range_a: assert property ((r.state == RSI_ST_SCRUB && r.standby) |->
    (mem_we && mem_waddr >= `RSI_SCRUB_LO && mem_waddr <= `RSI_SCRUB_HI))
    else $error("standby scrub outside window");

endmodule : rsi_reset_init
`default_nettype wire

// file: logic/rsi_defs.svh
// constants for the reset state initialiser: offsets, reset values, timing
// How it works
// - reset pin low reinitialises state; standby and operating resets differ
// - after release wait 31.3 ms before any instruction runs
// - pc[13:8] from byte 0000h low six bits, pc[7:0] from byte 0001h
// - byte 0000h bit 6 loads reg bank enable, bit 7 mem bank enable
// - skip and interrupt status bits cleared; carry kept on standby, poisoned otherwise
// - data memory kept on standby except f8h-fdh; all poisoned otherwise
// - general registers kept on standby, poisoned on operating reset
// - memory bank select and register bank select cleared
// - stack pointer and stack bank select untouched by reset
// - event counter 0, modulo ffh, control 0, output enable and level 0
// - pulse period registers kept, pulse control cleared
// - serial 0 shift and slave address kept on standby; controls cleared
// - serial 0 clock pin latch set to 1
// - converter control becomes 04h; approximation result untouched
// - cpu clock, system clock and clock output controls cleared
// - serial 1 shift kept on standby; control and done flag cleared
// - interrupt requests, enables, master enable and edge selects cleared
// - port outputs off, latches, direction groups and pull-ups cleared
// - bit sequential buffers kept on standby, poisoned otherwise
// - reset from stop or halt runs the full sequence, no resume
`ifndef RSI_DEFS_SVH
`define RSI_DEFS_SVH

// register byte offsets (low six address bits)
`define RSI_OFF_CTRL    6'h00
`define RSI_OFF_STATUS  6'h04
`define RSI_OFF_CPU     6'h08
`define RSI_OFF_STACK   6'h0c
`define RSI_OFF_GREG    6'h10
`define RSI_OFF_TIMER   6'h14
`define RSI_OFF_PULSE   6'h18
`define RSI_OFF_SER0    6'h1c
`define RSI_OFF_SER1    6'h20
`define RSI_OFF_INT     6'h24
`define RSI_OFF_PORT    6'h28
`define RSI_OFF_SEQBUF  6'h2c
// data memory window 0x400..0x7fc, one nibble per word
`define RSI_RAM_SEL     2'h1

// field positions of the cpu clock control
`define RSI_CLKCTL_STOP_BIT 3
`define RSI_CLKCTL_HALT_BIT 2

// reset values
`define RSI_MODULO_RST  8'hff
`define RSI_CONV_RST    8'h04
`define RSI_SER0_CLK_RST 1'h1
`define RSI_UNDEF_BYTE  8'ha5
`define RSI_UNDEF_NIB   4'ha
`define RSI_SCRUB_LO    8'hf8
`define RSI_SCRUB_HI    8'hfd
`define RSI_SCRUB_END   8'hff
`define RSI_VEC_ADDR_HI 16'h0000
`define RSI_VEC_ADDR_LO 16'h0001

// timing: 31.3 ms stabilisation (4.19 MHz main clock) at a 125 MHz hclk
`define RSI_STAB_WAIT_US 31300
`define RSI_CLK_MHZ      125
`define RSI_STAB_CYCLES  (`RSI_STAB_WAIT_US * `RSI_CLK_MHZ)

`endif

// file: logic/rsi_pkg.sv
// types of the reset state initialiser
`default_nettype none
`include "rsi_defs.svh"
package rsi_pkg;

  typedef enum logic [7:0] {
    RSI_ST_HOLD  = 8'h01,
    RSI_ST_SCRUB = 8'h02,
    RSI_ST_WAIT  = 8'h04,
    RSI_ST_VEC_A = 8'h08,
    RSI_ST_VEC_B = 8'h10,
    RSI_ST_VEC_C = 8'h20,
    RSI_ST_VEC_D = 8'h40,
    RSI_ST_RUN   = 8'h80
  } rsi_state_t;

  typedef struct packed {
    rsi_state_t  state;
    logic        rst_meta;
    logic        rst_sync;
    logic        standby;
    logic [21:0] wait_cnt;
    logic [7:0]  scrub_addr;
    logic [7:0]  vec_hi;
    logic [15:0] pmem_addr;
    logic        pmem_rd;
    logic        cpu_run;
    logic [11:0] a_addr;
    logic        a_write;
    logic        a_ram_rd;
    logic        hready;
    logic [31:0] hrdata;
    logic        hresp;
    logic [13:0] pc;
    logic        carry_flag;
    logic [2:0]  skip_flags;
    logic [1:0]  int_status_bits;
    logic        mem_bank_enable;
    logic        reg_bank_enable;
    logic [3:0]  mem_bank_select;
    logic [1:0]  reg_bank_select;
    logic [7:0]  stack_pointer;
    logic [3:0]  stack_bank_select;
    logic [31:0] greg;
    logic [7:0]  basic_interval_count;
    logic [3:0]  basic_interval_control;
    logic [7:0]  event_counter_value;
    logic [7:0]  event_counter_modulo;
    logic [7:0]  event_counter_control;
    logic        event_output_enable;
    logic        event_out_level;
    logic [7:0]  pulse_period_high;
    logic [7:0]  pulse_period_low;
    logic [7:0]  pulse_gen_control;
    logic [7:0]  watch_control;
    logic [7:0]  serial0_shift_reg;
    logic [7:0]  serial0_control;
    logic [7:0]  serial_bus_control;
    logic [7:0]  slave_addr_reg;
    logic        serial0_clock_latch;
    logic [7:0]  converter_control;
    logic [7:0]  approx_result_reg;
    logic [3:0]  cpu_clock_control;
    logic [3:0]  system_clock_select;
    logic [3:0]  clock_output_control;
    logic [7:0]  serial1_shift_reg;
    logic [7:0]  serial1_control;
    logic        serial1_done_flag;
    logic [7:0]  int_request_flags;
    logic [7:0]  interrupt_enable_flags;
    logic        int_master_enable;
    logic [11:0] ext_int_edge_select;
    logic [15:0] port_latch;
    logic [11:0] port_dir_groups;
    logic [3:0]  port_pullup_group_a;
    logic [15:0] bit_seq_buffers;
  } rsi_regs_t;

  localparam rsi_regs_t RSI_REGS_RST = '{
    state:                RSI_ST_HOLD,
    hready:               1'b1,
    event_counter_modulo: `RSI_MODULO_RST,
    serial0_clock_latch:  `RSI_SER0_CLK_RST,
    converter_control:    `RSI_CONV_RST,
    default:              '0
  };

endpackage : rsi_pkg
`default_nettype wire

// file: logic/rsi_data_mem.sv
// data memory of the reset state initialiser, registered read port
`default_nettype none
module rsi_data_mem (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // write port
  input  wire logic       we,
  input  wire logic [7:0] waddr,
  input  wire logic [3:0] wdata,
  // read port
  input  wire logic [7:0] raddr,
  output logic      [3:0] rdata_ff
);

  logic [3:0] mem [0:255];

  // no reset on the array: contents outside f8h-fdh survive a standby reset
  always_ff @(posedge hclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_ff <= 4'h0;
    end else begin
      rdata_ff <= mem[raddr];
    end
  end

endmodule : rsi_data_mem
`default_nettype wire

// file: bench/rsi_pin_src.sv
// external reset pin source: one low pulse per request, off the clock edge
`default_nettype none
module rsi_pin_src (
  // clock
  input  wire logic       hclk,
  // request and extra length
  input  wire logic       fire,
  input  wire logic [3:0] hold_cyc,
  // pin
  output logic            ext_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial ext_reset_n = 1'b1;
  // pin is asynchronous to hclk, so both edges land between clock edges
  always begin
    @(posedge hclk iff fire);
    #1.3 ext_reset_n = 1'b0;
    repeat (hold_cyc + 5) @(posedge hclk);
    #2.9 ext_reset_n = 1'b1;
  end
endmodule : rsi_pin_src
`default_nettype wire

// file: bench/rsi_reset_init_test.sv
// self-checking bench of the reset state initialiser
`default_nettype none
module rsi_reset_init_test;
  import rsi_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, pmem_rd, cpu_run;
  logic        mem_bank_enable, reg_bank_enable, serial0_clock_latch;
  logic        ext_reset_n, fire, dphase;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [15:0] pmem_addr, port_latch_out;
  logic [13:0] start_pc;
  logic [7:0]  pmem_data, v0, v1;
  logic [3:0]  hold_cyc, r10;
  logic [63:0] notes[$];
  logic [31:0] m[16];
  int          seed = 23976;
  int          n_errors = 0;
  int          comparisons = 0;
  ////////////////////////////////////////////////////////////////////////
  // short wait keeps the run small; scrub and vector phases stay full length
  rsi_reset_init #(.STAB_CYCLES(20)) rsi_reset_init_i (
    .hclk(hclk), .hresetn(hresetn), .ext_reset_n(ext_reset_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .pmem_addr(pmem_addr), .pmem_rd(pmem_rd), .pmem_data(pmem_data),
    .cpu_run(cpu_run), .start_pc(start_pc),
    .mem_bank_enable(mem_bank_enable), .reg_bank_enable(reg_bank_enable),
    .serial0_clock_latch(serial0_clock_latch), .port_latch_out(port_latch_out));
  rsi_pin_src rsi_pin_src_i (
    .hclk(hclk), .fire(fire), .hold_cyc(hold_cyc), .ext_reset_n(ext_reset_n));
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // program memory: one cycle late, garbage when not read
  always @(posedge hclk) pmem_data <= pmem_rd ? (pmem_addr[0] ? v1 : v0) : ~pmem_data;
  always @(posedge hclk) if (dphase && hreadyout && notes.size() > 0) begin
    chk(hrdata & notes[0][63:32], notes[0][31:0]);
    chk({31'h0, hresp}, 32'h0);
    notes.delete(0);
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic results();
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    int n;
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d; dphase <= !w;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    dphase <= 1'b0;
    if (n >= 100) begin n_errors++; results(); end
  endtask : xfer
  task automatic rd(input logic [31:0] a, input logic [31:0] mk, input logic [31:0] e);
    notes.push_back({mk, e});
    xfer(a, 1'b0, 32'h0);
  endtask : rd
  task automatic wait_run(input logic want);
    int n;
    n = 0;
    do begin @(posedge hclk); n++; end while (cpu_run !== want && n < 1000);
    if (n >= 1000) begin n_errors++; results(); end
  endtask : wait_run
  // retained fields follow m; poisoned ones read back as a5 bytes
  function automatic logic [63:0] want(input int i, input logic sb);
    case (i)
      3: return {32'h0fffffff, 4'h0, m[3][27:0]};
      4: return {32'hffffffff, sb ? m[4] : 32'ha5a5a5a5};
      5: return {32'h3fffffff, 32'h0000ff00};
      6: return {32'hffffffff, 16'h0, m[6][15:0]};
      7: return {32'hffffffff, sb ? m[7][31:24] : 8'ha5, 16'h0, sb ? m[7][7:0] : 8'ha5};
      8: return {32'h03ffffff, 24'h020400, sb ? m[8][7:0] : 8'ha5};
      11: return {32'h0000ffff, 16'h0, sb ? m[11][15:0] : 16'ha5a5};
      default: return {32'hffffffff, 32'h0};
    endcase
  endfunction : want
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic sb;
    logic [63:0] w;
    hresetn = 1'b0; hsel = 1'b0; htrans = 2'h0; haddr = '0; hwrite = 1'b0;
    hwdata = '0; fire = 1'b0; hold_cyc = '0; dphase = 1'b0; pmem_data = '0;
    v0 = '0; v1 = '0; r10 = '0; m = '{default: '0};
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int k = 0; k < 4; k++) begin
      sb = (k == 1 || k == 2);
      v0 <= $random(seed); v1 <= $random(seed); hold_cyc <= $random(seed); fire <= 1'b1;
      @(posedge hclk);
      fire <= 1'b0;
      wait_run(1'b0);
      wait_run(1'b1);
      chk({18'h0, start_pc}, {18'h0, v0[5:0], v1});
      chk({30'h0, reg_bank_enable, mem_bank_enable}, {30'h0, v0[6], v0[7]});
      chk({15'h0, serial0_clock_latch, port_latch_out}, 32'h00010000);
      rd(32'h04, 32'h0000ff03, {16'h0, 8'h80, 6'h0, sb, 1'b1});
      rd(32'h00, 32'h00000fff, 32'h0);
      rd(32'h08, 32'h0fffffff,
         {10'h0, v0[6], v0[7], 5'h0, sb ? m[2][14] : 1'b1, v0[5:0], v1});
      for (int i = 3; i < 13; i++) begin
        w = want(i, sb);
        rd(i * 4, w[63:32], w[31:0]);
      end
      rd(32'h440, 32'hf, sb ? {28'h0, r10} : 32'ha);
      rd(32'h7e4, 32'hf, 32'ha);
      for (int i = 2; i < 13; i++) begin
        m[i] = $random(seed);
        xfer(i * 4, 1'b1, m[i]);
      end
      r10 = $random(seed);
      xfer(32'h440, 1'b1, {28'h0, r10});
      xfer(32'h7e4, 1'b1, $random(seed));
      // stop, then halt, then plain run before the next pin reset
      xfer(32'h00, 1'b1, {28'h0, k == 0, k == 1, 2'h0});
    end
    results();
  end
endmodule : rsi_reset_init_test
`default_nettype wire
